// ===== rtl/fcb_pkg.sv
// Constants and carrier types of the filter configuration bank.
// Assumes one 50 MHz clock domain and an access port that is fed by the
// device's serial host port decoder.
package fcb_pkg;
   // -----------------------------------------------------------------
   // Register map
   // -----------------------------------------------------------------
   localparam int ADDR_W = 6;
   localparam int DATA_W = 16;
   localparam int SETUP_W = 3;
   localparam logic [ADDR_W-1:0] FILTER_CONFIG_0_ADDR = 6'h28;
   localparam logic [ADDR_W-1:0] FILTER_CONFIG_7_ADDR = 6'h2f;
   localparam logic [DATA_W-1:0] FILTER_CONFIG_RESET = 16'h0500;
   // Bits that software may change; the rest read as zero
   localparam logic [DATA_W-1:0] FILTER_CONFIG_WMASK = 16'h8f7f;
   localparam logic [DATA_W-1:0] DIRECT_MAP_WMASK = 16'hffff;

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int DIRECT_MAP_BIT = 15;
   localparam int DIRECT_RATE_MSB = 14;
   localparam int PF_EN_BIT = 11;
   localparam int PF_SEL_MSB = 10;
   localparam int PF_SEL_LSB = 8;
   localparam int ORDER_MSB = 6;
   localparam int ORDER_LSB = 5;
   localparam int RATE_MSB = 4;

   // -----------------------------------------------------------------
   // Field encodings
   // -----------------------------------------------------------------
   localparam logic [1:0] ORDER_SINC5_SINC1 = 2'h0;
   localparam logic [1:0] ORDER_SINC3 = 2'h3;
   localparam logic [2:0] PF_27SPS = 3'h2;
   localparam logic [2:0] PF_25SPS = 3'h3;
   localparam logic [2:0] PF_20SPS = 3'h5;
   localparam logic [2:0] PF_16SPS = 3'h6;
   localparam logic [4:0] RATE_LAST_FASTEST = 5'h02;
   localparam logic [4:0] RATE_SLOWEST = 5'h16;
   // Post filter settling times in microseconds
   localparam logic [15:0] SETTLE_27SPS_US = 16'h8f5c; // 36.7 ms
   localparam logic [15:0] SETTLE_25SPS_US = 16'h9c40; // 40 ms
   localparam logic [15:0] SETTLE_20SPS_US = 16'hc350; // 50 ms
   localparam logic [15:0] SETTLE_16SPS_US = 16'hea60; // 60 ms
   // Modulator periods per result for each direct decimation step
   localparam int DIRECT_PERIOD_SHIFT = 5; // times 32
   localparam int PERIOD_W = 20;

   // -----------------------------------------------------------------
   // Carriers
   // -----------------------------------------------------------------
   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } fcb_acc_s;

   typedef struct packed {
      logic direct_mode;
      logic [14:0] direct_rate;
      logic [PERIOD_W-1:0] result_period;
      logic [1:0] order;
      logic [4:0] rate_code;
      logic [4:0] rate_step;
      logic pf_enable;
      logic [2:0] pf_select;
      logic [15:0] settle_us;
      logic code_undefined;
   } fcb_cfg_s;
endpackage : fcb_pkg

// ===== rtl/fcb_filter_config_bank.sv
// Bank of per-setup filter configuration registers with decode.
// Assumes the host port decoder presents one access per cycle on i_acc
// and the channel sequencer names the setup it is about to convert.
`timescale 1ns/10ps
module fcb_filter_config_bank #(
   parameter int NUM_SETUPS = 8
) (
   input wire logic i_sys_clk, // 50 MHz clock
   input wire logic i_rst_b, // Async reset, active low
   input wire fcb_pkg::fcb_acc_s i_acc, // Register access
   input wire logic [fcb_pkg::SETUP_W-1:0] i_setup_sel, // Active setup
   output logic [fcb_pkg::DATA_W-1:0] o_rd_data, // Read data
   output logic o_rd_valid, // Read answer strobe
   output logic o_rd_hit, // Read hit a mapped register
   output logic o_conv_abort, // Abort conversion pulse
   output logic o_seq_restart, // Restart at first channel pulse
   output fcb_pkg::fcb_cfg_s o_cfg // Decoded config of active setup
);
   import fcb_pkg::*;

   // -----------------------------------------------------------------
   // Elaboration checks
   // -----------------------------------------------------------------
   if (NUM_SETUPS < 1 || NUM_SETUPS > (1 << SETUP_W)) begin : g_chk
      $error("NUM_SETUPS must lie between 1 and 8");
   end

   // -----------------------------------------------------------------
   // Address decode
   // -----------------------------------------------------------------
   logic in_bank;
   logic [SETUP_W-1:0] acc_idx;
   logic idx_ok;

   assign in_bank = (i_acc.addr >= FILTER_CONFIG_0_ADDR) &&
                    (i_acc.addr <= FILTER_CONFIG_7_ADDR);
   assign acc_idx = i_acc.addr[SETUP_W-1:0];
   assign idx_ok = in_bank && (32'(acc_idx) < NUM_SETUPS);

   // -----------------------------------------------------------------
   // Register storage
   // -----------------------------------------------------------------
   logic [DATA_W-1:0] cfg_q [NUM_SETUPS];

   // Direct map reuses bits 14:12 and 7, so the mask follows bit 15
   function automatic logic [DATA_W-1:0] store_val(
      input logic [DATA_W-1:0] wd
   );
      logic [DATA_W-1:0] m;
      m = wd[DIRECT_MAP_BIT] ? DIRECT_MAP_WMASK
                             : FILTER_CONFIG_WMASK;
      store_val = wd & m;
   endfunction : store_val

   for (genvar s = 0; s < NUM_SETUPS; s++) begin : g_reg
      always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
         if (!i_rst_b) begin
            cfg_q[s] <= FILTER_CONFIG_RESET;
         end else if (i_acc.wr && idx_ok &&
                      acc_idx == SETUP_W'(s)) begin
            cfg_q[s] <= store_val(i_acc.wdata);
         end
      end
   end

   // -----------------------------------------------------------------
   // Read path
   // -----------------------------------------------------------------
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_rd_data <= '0;
         o_rd_valid <= 1'b0;
         o_rd_hit <= 1'b0;
      end else begin
         o_rd_valid <= i_acc.rd;
         o_rd_hit <= i_acc.rd && idx_ok;
         if (i_acc.rd && idx_ok) begin
            o_rd_data <= cfg_q[acc_idx];
         end else begin
            o_rd_data <= '0;
         end
      end
   end

   // -----------------------------------------------------------------
   // Conversion restart
   // -----------------------------------------------------------------
   // Any accepted write, even one that leaves the value unchanged,
   // restarts so that the sequencer never mixes old and new settings.
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_conv_abort <= 1'b0;
         o_seq_restart <= 1'b0;
      end else begin
         o_conv_abort <= i_acc.wr && idx_ok;
         o_seq_restart <= i_acc.wr && idx_ok;
      end
   end

   // -----------------------------------------------------------------
   // Decode of the active setup
   // -----------------------------------------------------------------
   logic [DATA_W-1:0] sel_q;
   fcb_cfg_s next_cfg;
   logic sel_ok;

   assign sel_ok = 32'(i_setup_sel) < NUM_SETUPS;
   assign sel_q = sel_ok ? cfg_q[i_setup_sel] : FILTER_CONFIG_RESET;

   always_comb begin
      logic [1:0] ord;
      logic [4:0] rc;
      logic [2:0] pfs;
      logic pf_bad;
      ord = sel_q[ORDER_MSB:ORDER_LSB];
      rc = sel_q[RATE_MSB:0];
      pfs = sel_q[PF_SEL_MSB:PF_SEL_LSB];
      pf_bad = 1'b0;
      next_cfg = '0;
      if (sel_q[DIRECT_MAP_BIT]) begin
         // Every other field loses its meaning here
         next_cfg.direct_mode = 1'b1;
         next_cfg.direct_rate = sel_q[DIRECT_RATE_MSB:0];
         next_cfg.order = ORDER_SINC3;
         next_cfg.result_period = {PERIOD_W'(sel_q[DIRECT_RATE_MSB:0])}
                                  << DIRECT_PERIOD_SHIFT;
         // Zero decimation would give no results at all
         next_cfg.code_undefined = (sel_q[DIRECT_RATE_MSB:0] == '0);
      end else begin
         next_cfg.order = ord;
         next_cfg.rate_code = rc;
         // Codes 0 to 2 share the fastest rate, later codes step down
         if (rc <= RATE_LAST_FASTEST) begin
            next_cfg.rate_step = '0;
         end else begin
            next_cfg.rate_step = rc - RATE_LAST_FASTEST;
         end
         next_cfg.pf_select = pfs;
         // Post filter only acts behind the sinc5 plus sinc1 path
         next_cfg.pf_enable = sel_q[PF_EN_BIT] &&
                              (ord == ORDER_SINC5_SINC1);
         case (pfs)
            PF_27SPS: next_cfg.settle_us = SETTLE_27SPS_US;
            PF_25SPS: next_cfg.settle_us = SETTLE_25SPS_US;
            PF_20SPS: next_cfg.settle_us = SETTLE_20SPS_US;
            PF_16SPS: next_cfg.settle_us = SETTLE_16SPS_US;
            default: begin
               next_cfg.settle_us = '0;
               pf_bad = 1'b1;
            end
         endcase
         if (!next_cfg.pf_enable) begin
            next_cfg.settle_us = '0;
         end
         // Flag codes the host must not use; behaviour is not defined
         next_cfg.code_undefined =
            (ord != ORDER_SINC5_SINC1 && ord != ORDER_SINC3) ||
            (next_cfg.pf_enable && pf_bad) ||
            (rc > RATE_SLOWEST);
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_cfg <= '0;
      end else begin
         o_cfg <= next_cfg;
      end
   end
endmodule : fcb_filter_config_bank

// ===== tb/fcb_filter_config_bank_monitor.sv
// Port assertions for the filter configuration bank.
// Assumes one clock domain; attached to the bank by bind.
`timescale 1ns/10ps
module fcb_filter_config_bank_monitor (
   input wire logic i_sys_clk, // Clock
   input wire logic i_rst_b, // Reset, active low
   input wire fcb_pkg::fcb_acc_s i_acc, // Access
   input wire logic [2:0] i_setup_sel, // Setup
   input wire logic [15:0] o_rd_data, // Read data
   input wire logic o_rd_valid, // Read strobe
   input wire logic o_rd_hit, // Read hit
   input wire logic o_conv_abort, // Abort
   input wire logic o_seq_restart, // Restart
   input wire fcb_pkg::fcb_cfg_s o_cfg // Decode
);
   import fcb_pkg::*;
   // ---------------
   // Properties
   // ---------------
   wire logic mapped = i_acc.addr[5:3] == 3'h5;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_b);
   property p_ab; i_acc.wr && mapped |=> o_conv_abort && o_seq_restart;
   endproperty
   a_ab: assert property (p_ab) else $error("no abort");
   property p_nab; !(i_acc.wr && mapped) |=> !o_conv_abort; endproperty
   a_nab: assert property (p_nab) else $error("stray abort");
   property p_rdv; i_acc.rd |=> o_rd_valid; endproperty
   a_rdv: assert property (p_rdv) else $error("no read strobe");
   property p_hit; i_acc.rd |=> o_rd_hit == $past(mapped); endproperty
   a_hit: assert property (p_hit) else $error("bad hit");
   property p_unm; i_acc.rd && !mapped |=> o_rd_data == 16'h0; endproperty
   a_unm: assert property (p_unm) else $error("unmapped data");
   property p_rsv; o_rd_valid && !o_rd_data[15]
      |-> o_rd_data[14:12] == 3'h0 && !o_rd_data[7]; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved set");
   property p_pf; o_cfg.pf_enable |-> o_cfg.order == 2'h0; endproperty
   a_pf: assert property (p_pf) else $error("post filter");
   property p_per; o_cfg.direct_mode
      |-> o_cfg.result_period == {o_cfg.direct_rate, 5'h00}; endproperty
   a_per: assert property (p_per) else $error("bad period");
   c_wr: cover property (i_acc.wr && mapped);
   c_dir: cover property (o_cfg.direct_mode);
   c_pf: cover property (o_cfg.pf_enable);
endmodule : fcb_filter_config_bank_monitor
bind fcb_filter_config_bank fcb_filter_config_bank_monitor fcb_mon_inst (
   .i_sys_clk, .i_rst_b, .i_acc, .i_setup_sel, .o_rd_data, .o_rd_valid,
   .o_rd_hit, .o_conv_abort, .o_seq_restart, .o_cfg);

// ===== tb/fcb_filter_config_bank_test.sv
// Self-checking bench for the filter configuration bank.
// Assumes the bank and its bound monitor are compiled before it.
`timescale 1ns/10ps
module fcb_filter_config_bank_test;
   import fcb_pkg::*;
   logic i_sys_clk = 0;
   logic i_rst_b = 0;
   fcb_acc_s i_acc = '0;
   logic [2:0] i_setup_sel = 0;
   logic [15:0] o_rd_data;
   logic o_rd_valid, o_rd_hit, o_conv_abort, o_seq_restart;
   fcb_cfg_s o_cfg;
   int err_total = 0, compares = 0, seed = 32'h11997985;
   logic [31:0] r;
   logic [22:0] got, want;
   logic [15:0] mdl [8];
   logic [16:0] rdq [$];
   logic [1:0] abq [$];
   logic [15:0] cw [5] = '{16'h0a02, 16'h0b03, 16'h0d16, 16'h0e60, 16'h0e07};
   logic [22:0] ce [5] = '{{2'b01, 16'h8f5c, 5'h00}, {2'b01, 16'h9c40, 5'h01},
      {2'b01, 16'hc350, 5'h14}, {2'b00, 16'h0, 5'h00}, {2'b01, 16'hea60, 5'h05}};
   fcb_filter_config_bank fcb_filter_config_bank_inst (.i_sys_clk, .i_rst_b,
      .i_acc, .i_setup_sel, .o_rd_data, .o_rd_valid, .o_rd_hit,
      .o_conv_abort, .o_seq_restart, .o_cfg);
   initial forever #10 i_sys_clk = ~i_sys_clk;
   // ---------------
   // Tasks
   // ---------------
   task automatic chk(input logic [22:0] g, input logic [22:0] e);
      compares++;
      if (g !== e) begin
         err_total++;
         $display("unexpected t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic chk_rd(input logic [16:0] g, input logic [16:0] e);
      chk({6'h0, g}, {6'h0, e});
   endtask : chk_rd
   task automatic chk_ab(input logic [1:0] g, input logic [1:0] e);
      chk({21'h0, g}, {21'h0, e});
   endtask : chk_ab
   task automatic chk_cfg(input logic [22:0] g, input logic [22:0] e);
      chk(g, e);
   endtask : chk_cfg
   task automatic acc(input logic w, r, input logic [5:0] a, logic [15:0] d);
      @(posedge i_sys_clk) #1;
      i_acc = {w, r, a, d};
      // Read sees the old word when a write lands in the same cycle
      if (r) rdq.push_back(a[5:3] == 3'h5 ? {1'b1, mdl[a[2:0]]} : 17'h0);
      if (w && a[5:3] == 3'h5) abq.push_back(2'b11);
      if (w && a[5:3] == 3'h5) mdl[a[2:0]] = d[15] ? d : d & 16'h8f7f;
   endtask : acc
   task automatic give_verdict;
      $display("err_total=%0d compares=%0d", err_total, compares);
      if (err_total == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict
   always @(negedge i_sys_clk) begin
      if (o_rd_valid === 1'b1) begin
         chk_rd({o_rd_hit, o_rd_data}, rdq.pop_front());
      end
      // A pulse with no pending write note pops the default of all X
      if (o_conv_abort !== 1'b0 || o_seq_restart !== 1'b0) begin
         chk_ab({o_conv_abort, o_seq_restart}, abq.pop_front());
      end
   end
   initial begin
      #100000;
      err_total++;
      give_verdict();
   end
   // ---------------
   // Sequence
   // ---------------
   initial begin
      foreach (mdl[i]) mdl[i] = 16'h0500;
      repeat (10) @(posedge i_sys_clk);
      #1 i_rst_b = 1;
      for (int i = 39; i < 49; i++) acc(0, 1, 6'(i), 0);
      repeat (60) begin
         r = $random(seed);
         acc(1, r[16], {2'b10, r[20:17]}, r[15:0]);
      end
      for (int i = 40; i < 48; i++) acc(0, 1, 6'(i), 0);
      foreach (cw[i]) begin
         r = $random(seed);
         acc(1, 0, {3'h5, r[2:0]}, cw[i]);
         i_setup_sel = r[2:0];
         acc(0, 0, 0, 0);
         // Decode follows the stored word one edge after the write lands
         @(posedge i_sys_clk);
         @(negedge i_sys_clk);
         got = {o_cfg.code_undefined, o_cfg.pf_enable, o_cfg.settle_us,
                o_cfg.rate_step};
         chk_cfg(got, ce[i]);
         got = {13'h0, o_cfg.order, o_cfg.rate_code, o_cfg.pf_select};
         want = {13'h0, cw[i][6:5], cw[i][4:0], cw[i][10:8]};
         chk_cfg(got, want);
      end
      acc(1, 0, {3'h5, r[2:0]}, 16'h8010);
      acc(0, 0, 0, 0);
      @(posedge i_sys_clk);
      @(negedge i_sys_clk);
      got = {2'b0, o_cfg.direct_mode, o_cfg.result_period};
      chk_cfg(got, 23'h100200);
      got = {8'h0, o_cfg.direct_rate};
      chk_cfg(got, 23'h000010);
      @(posedge i_sys_clk) #1;
      i_setup_sel = r[2:0] ^ 3'h1;
      @(posedge i_sys_clk);
      @(negedge i_sys_clk);
      got = {22'h0, o_cfg.direct_mode};
      want = {22'h0, mdl[r[2:0] ^ 3'h1][15]};
      chk_cfg(got, want);
      // Every read and every mapped write must have been answered
      chk_rd(17'(rdq.size() + abq.size()), 17'h0);
      give_verdict();
   end
endmodule : fcb_filter_config_bank_test
